// *** rtl/crs_pkg.sv ***
package crs_pkg;
    // ------------------------------------------------------------
    // System register numbers
    // ------------------------------------------------------------
    localparam logic [4:0] SR_MASKABLE_PC_SAVE = 5'h00;
    localparam logic [4:0] SR_MASKABLE_PSW_SAVE = 5'h01;
    localparam logic [4:0] SR_NMI_PC_SAVE = 5'h02;
    localparam logic [4:0] SR_NMI_PSW_SAVE = 5'h03;
    localparam logic [4:0] SR_EXCEPTION_SOURCE_CODE = 5'h04;
    localparam logic [4:0] SR_PROGRAM_STATUS_WORD = 5'h05;
    localparam logic [4:0] SR_TABLE_CALL_PC_SAVE = 5'h10;
    localparam logic [4:0] SR_TABLE_CALL_PSW_SAVE = 5'h11;
    localparam logic [4:0] SR_DEBUG_PC_SAVE = 5'h12;
    localparam logic [4:0] SR_DEBUG_PSW_SAVE = 5'h13;
    localparam logic [4:0] SR_TABLE_CALL_BASE = 5'h14;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PC_MASK = 32'h03FF_FFFE;
    localparam logic [31:0] PSW_MASK = 32'h0000_00FF;
    localparam logic [4:0] GPR_ZERO = 5'h00;
    localparam logic [4:0] GPR_ELEMENT_PTR = 5'h1E;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] PSW_RESET = 32'h0000_0020;
    // ------------------------------------------------------------
    // Exception event kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EXC_NONE = 2'b00,
        EXC_MASKABLE = 2'b01,
        EXC_NMI = 2'b10,
        EXC_TABLE_CALL = 2'b11
    } crs_exc_type;
endpackage

// *** rtl/crs_register_set.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Thirty-two 32-bit general registers, all 32-bit
// - Register zero always reads zero
// - Register 30 is short access base pointer
// - PC keeps 26 bits, carry dropped
// - PC bit 0 held at zero
// - System registers reached by load/store only
// - Fixed system register numbering map
// - Reserved numbers accept no access
// - Debug saves only inside debug window
// - Maskable event saves PC and PROGRAM_STATUS_WORD
// - Saved PC is next instruction address
// - NMI saves into NMI pair
// - Save registers clear their reserved upper bits
// - Interrupt return restores PC and PROGRAM_STATUS_WORD
// - Returned PC ignores saved bit 0
// - Maskable and NMI events record their source code; table call leaves it unchanged
// - Source code register is read-only
// - PROGRAM_STATUS_WORD write effective next; interrupts held off
// - Table call saves next PC and PROGRAM_STATUS_WORD
module crs_register_set (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [4:0] gpr_rd_a_sel_i,
    output logic [31:0] gpr_rd_a_data_o,
    input wire logic [4:0] gpr_rd_b_sel_i,
    output logic [31:0] gpr_rd_b_data_o,
    output logic [31:0] element_ptr_o,
    input wire logic gpr_wr_en_i,
    input wire logic [4:0] gpr_wr_sel_i,
    input wire logic [31:0] gpr_wr_data_i,
    input wire logic pc_load_en_i,
    input wire logic [31:0] pc_load_value_i,
    input wire logic [31:0] next_pc_i,
    output logic [31:0] pc_o,
    input wire logic psw_flags_en_i,
    input wire logic [31:0] psw_flags_i,
    output logic [31:0] psw_o,
    input wire logic system_register_load_i,
    input wire logic system_register_store_i,
    input wire logic [4:0] sr_sel_i,
    input wire logic [31:0] sr_wr_data_i,
    output logic [31:0] sr_rd_data_o,
    output logic sr_access_err_o,
    input wire logic [1:0] exc_kind_i,
    input wire logic [15:0] exc_code_i,
    input wire logic interrupt_return_i,
    input wire logic debug_trap_i,
    input wire logic debug_return_i,
    output logic irq_hold_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0][31:0] gpr;
        logic [31:0] pc;
        logic [31:0] program_status_word;
        logic [31:0] mpc;
        logic [31:0] mpsw;
        logic [31:0] npc;
        logic [31:0] npsw;
        logic [31:0] exception_source_code;
        logic [31:0] tpc;
        logic [31:0] tpsw;
        logic [31:0] dpc;
        logic [31:0] dpsw;
        logic [31:0] tbase;
        logic dbg_win;
        logic [31:0] rd;
        logic err;
    } crs_state_type;

    crs_state_type st;
    crs_state_type next_st;

    // ------------------------------------------------------------
    // Register number decoding
    // ------------------------------------------------------------

    function automatic logic sr_ok(input logic [4:0] n, input logic ld, input logic win);
        case (n)
            crs_pkg::SR_MASKABLE_PC_SAVE, crs_pkg::SR_MASKABLE_PSW_SAVE,
            crs_pkg::SR_NMI_PC_SAVE, crs_pkg::SR_NMI_PSW_SAVE,
            crs_pkg::SR_PROGRAM_STATUS_WORD, crs_pkg::SR_TABLE_CALL_PC_SAVE,
            crs_pkg::SR_TABLE_CALL_PSW_SAVE, crs_pkg::SR_TABLE_CALL_BASE: sr_ok = 1'b1;
            crs_pkg::SR_EXCEPTION_SOURCE_CODE: sr_ok = !ld;
            crs_pkg::SR_DEBUG_PC_SAVE, crs_pkg::SR_DEBUG_PSW_SAVE: sr_ok = win;
            default: sr_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] gpr_read(input crs_state_type s, input logic [4:0] n);
        gpr_read = (n == crs_pkg::GPR_ZERO) ? crs_pkg::RESET_VALUE : s.gpr[n];
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic ld_ok;
    logic st_ok;
    assign ld_ok = system_register_load_i && sr_ok(sr_sel_i, 1'b1, st.dbg_win);
    assign st_ok = system_register_store_i && sr_ok(sr_sel_i, 1'b0, st.dbg_win);

    always_comb begin
        next_st = st;
        next_st.err = (system_register_load_i && !ld_ok) || (system_register_store_i && !st_ok);
        if (gpr_wr_en_i && gpr_wr_sel_i != crs_pkg::GPR_ZERO) begin
            next_st.gpr[gpr_wr_sel_i] = gpr_wr_data_i;
        end
        // Stepping: PC wraps inside 26 bits, bit 0 forced low
        next_st.pc = next_pc_i & crs_pkg::PC_MASK;
        if (pc_load_en_i) begin
            next_st.pc = pc_load_value_i & crs_pkg::PC_MASK;
        end
        if (psw_flags_en_i) begin
            next_st.program_status_word = psw_flags_i & crs_pkg::PSW_MASK;
        end
        if (st_ok) begin
            case (sr_sel_i)
                crs_pkg::SR_MASKABLE_PC_SAVE: next_st.rd = st.mpc;
                crs_pkg::SR_MASKABLE_PSW_SAVE: next_st.rd = st.mpsw;
                crs_pkg::SR_NMI_PC_SAVE: next_st.rd = st.npc;
                crs_pkg::SR_NMI_PSW_SAVE: next_st.rd = st.npsw;
                crs_pkg::SR_EXCEPTION_SOURCE_CODE: next_st.rd = st.exception_source_code;
                crs_pkg::SR_PROGRAM_STATUS_WORD: next_st.rd = st.program_status_word;
                crs_pkg::SR_TABLE_CALL_PC_SAVE: next_st.rd = st.tpc;
                crs_pkg::SR_TABLE_CALL_PSW_SAVE: next_st.rd = st.tpsw;
                crs_pkg::SR_DEBUG_PC_SAVE: next_st.rd = st.dpc;
                crs_pkg::SR_DEBUG_PSW_SAVE: next_st.rd = st.dpsw;
                crs_pkg::SR_TABLE_CALL_BASE: next_st.rd = st.tbase;
                default: next_st.rd = crs_pkg::RESET_VALUE;
            endcase
        end
        // Stored bit 0 is kept as written; it is dropped only on return
        if (ld_ok) begin
            case (sr_sel_i)
                crs_pkg::SR_MASKABLE_PC_SAVE: next_st.mpc = sr_wr_data_i & (crs_pkg::PC_MASK | 32'h0000_0001);
                crs_pkg::SR_MASKABLE_PSW_SAVE: next_st.mpsw = sr_wr_data_i & crs_pkg::PSW_MASK;
                crs_pkg::SR_NMI_PC_SAVE: next_st.npc = sr_wr_data_i & (crs_pkg::PC_MASK | 32'h0000_0001);
                crs_pkg::SR_NMI_PSW_SAVE: next_st.npsw = sr_wr_data_i & crs_pkg::PSW_MASK;
                crs_pkg::SR_PROGRAM_STATUS_WORD: next_st.program_status_word = sr_wr_data_i & crs_pkg::PSW_MASK;
                crs_pkg::SR_TABLE_CALL_PC_SAVE: next_st.tpc = sr_wr_data_i & (crs_pkg::PC_MASK | 32'h0000_0001);
                crs_pkg::SR_TABLE_CALL_PSW_SAVE: next_st.tpsw = sr_wr_data_i & crs_pkg::PSW_MASK;
                crs_pkg::SR_DEBUG_PC_SAVE: next_st.dpc = sr_wr_data_i & (crs_pkg::PC_MASK | 32'h0000_0001);
                crs_pkg::SR_DEBUG_PSW_SAVE: next_st.dpsw = sr_wr_data_i & crs_pkg::PSW_MASK;
                crs_pkg::SR_TABLE_CALL_BASE: next_st.tbase = sr_wr_data_i;
                default: next_st.rd = st.rd;
            endcase
        end
        // Hardware events win over a same-cycle load of the same register
        case (exc_kind_i)
            crs_pkg::EXC_MASKABLE: begin
                next_st.mpc = next_pc_i & crs_pkg::PC_MASK;
                next_st.mpsw = st.program_status_word & crs_pkg::PSW_MASK;
                next_st.exception_source_code = {16'h0000, exc_code_i};
            end
            crs_pkg::EXC_NMI: begin
                next_st.npc = next_pc_i & crs_pkg::PC_MASK;
                next_st.npsw = st.program_status_word & crs_pkg::PSW_MASK;
                next_st.exception_source_code = {16'h0000, exc_code_i};
            end
            crs_pkg::EXC_TABLE_CALL: begin
                next_st.tpc = next_pc_i & crs_pkg::PC_MASK;
                next_st.tpsw = st.program_status_word & crs_pkg::PSW_MASK;
            end
            default: begin
                next_st.exception_source_code = next_st.exception_source_code;
            end
        endcase
        if (interrupt_return_i) begin
            next_st.pc = st.mpc & crs_pkg::PC_MASK;
            next_st.program_status_word = st.mpsw & crs_pkg::PSW_MASK;
        end
        // Trap wins a same-cycle return, so a live trap never finds the window shut
        if (debug_trap_i) begin
            next_st.dbg_win = 1'b1;
        end else if (debug_return_i) begin
            next_st.dbg_win = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.program_status_word <= crs_pkg::PSW_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign gpr_rd_a_data_o = gpr_read(st, gpr_rd_a_sel_i);
    assign gpr_rd_b_data_o = gpr_read(st, gpr_rd_b_sel_i);
    assign element_ptr_o = st.gpr[crs_pkg::GPR_ELEMENT_PTR];
    assign pc_o = st.pc;
    assign psw_o = st.program_status_word;
    assign sr_rd_data_o = st.rd;
    assign sr_access_err_o = st.err;
    // A PROGRAM_STATUS_WORD load in flight must not race with interrupt acknowledge
    assign irq_hold_o = system_register_load_i && sr_sel_i == crs_pkg::SR_PROGRAM_STATUS_WORD;

    // ------------------------------------------------------------
    // Checks: program registers
    // ------------------------------------------------------------
    AST_ZERO_REG: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        gpr_rd_a_sel_i == 5'h00 |-> gpr_rd_a_data_o == 32'h0000_0000)
        else $error("register zero read nonzero");
    AST_ZERO_PORT_B: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        gpr_rd_b_sel_i == 5'h00 |-> gpr_rd_b_data_o == 32'h0000_0000)
        else $error("register zero read nonzero on second port");
    AST_ZERO_WRITE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        st.gpr[0] == 32'h0000_0000)
        else $error("register zero storage changed");
    AST_GPR_WRITE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        gpr_wr_en_i && gpr_wr_sel_i == 5'h1E |=> element_ptr_o == $past(gpr_wr_data_i))
        else $error("base pointer not written");
    AST_PC_RANGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pc_o[31:26] == 6'h00 && pc_o[0] == 1'b0)
        else $error("pc out of range");
    AST_PC_EVEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !pc_load_en_i && !interrupt_return_i |=> pc_o == ($past(next_pc_i) & 32'h03FF_FFFE))
        else $error("pc step wrong");
    AST_PC_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pc_load_en_i && !interrupt_return_i |=> pc_o == ($past(pc_load_value_i) & 32'h03FF_FFFE))
        else $error("pc branch load wrong");
    // ------------------------------------------------------------
    // Checks: system register access
    // ------------------------------------------------------------
    AST_RESERVED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        system_register_store_i && sr_sel_i inside {[5'h06:5'h0F], [5'h15:5'h1F]} |=> sr_access_err_o)
        else $error("reserved number accepted");
    // A stray refusal pulse would look to the pipeline like a failed access
    AST_ERR_QUIET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !system_register_load_i && !system_register_store_i |=> !sr_access_err_o)
        else $error("refusal without access");
    // A shut window refuses both directions; the open and close checks guard the flag itself
    AST_DEBUG_WIN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (system_register_load_i || system_register_store_i) && sr_sel_i inside {5'h12, 5'h13} && !st.dbg_win |=> sr_access_err_o)
        else $error("debug save reached outside window");
    AST_DEBUG_OPEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        debug_trap_i |=> st.dbg_win)
        else $error("debug window not opened");
    AST_DEBUG_CLOSE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        debug_return_i && !debug_trap_i |=> !st.dbg_win)
        else $error("debug window not closed");
    sequence seq_psw_load;
        system_register_load_i && sr_sel_i == 5'h05 && !interrupt_return_i;
    endsequence
    AST_PSW_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_psw_load |=> psw_o == ($past(sr_wr_data_i) & 32'h0000_00FF))
        else $error("psw load not effective next cycle");
    sequence seq_psw_store;
        system_register_store_i && sr_sel_i == 5'h05;
    endsequence
    AST_STORE_PSW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_psw_store |=> sr_rd_data_o == $past(psw_o))
        else $error("status word store wrong");
    AST_PSW_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        system_register_load_i && sr_sel_i == 5'h05 |-> irq_hold_o)
        else $error("interrupt not held during psw load");
    AST_SRC_LOAD_REFUSED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        system_register_load_i && sr_sel_i == 5'h04 |=> sr_access_err_o)
        else $error("source code load accepted");
    // ------------------------------------------------------------
    // Checks: event saves and return
    // ------------------------------------------------------------
    sequence seq_mask_event;
        exc_kind_i == 2'b01 && !interrupt_return_i;
    endsequence
    AST_MASK_SAVE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_mask_event |=> st.mpc == ($past(next_pc_i) & 32'h03FF_FFFE) && st.mpsw == $past(psw_o))
        else $error("maskable save wrong");
    AST_NMI_SAVE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exc_kind_i == 2'b10 |=> st.npc[31:26] == 6'h00 && st.npsw == $past(psw_o))
        else $error("nmi save wrong");
    AST_NMI_PC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exc_kind_i == 2'b10 |=> st.npc == ($past(next_pc_i) & 32'h03FF_FFFE))
        else $error("nmi saved pc wrong");
    sequence seq_table_call;
        exc_kind_i == 2'b11;
    endsequence
    AST_TCALL_SAVE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_table_call |=> st.tpc == ($past(next_pc_i) & 32'h03FF_FFFE) && st.tpsw == $past(psw_o))
        else $error("table call save wrong");
    AST_SAVE_UPPER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        st.mpc[31:26] == 6'h00 && st.npc[31:26] == 6'h00 && st.tpc[31:26] == 6'h00 &&
        st.mpsw[31:8] == 24'h000000 && st.npsw[31:8] == 24'h000000 && st.tpsw[31:8] == 24'h000000)
        else $error("save register upper bits set");
    AST_SRC_RECORD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exc_kind_i inside {2'b01, 2'b10} |=> st.exception_source_code == {16'h0000, $past(exc_code_i)})
        else $error("source code not recorded");
    AST_SRC_RO: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exc_kind_i inside {2'b00, 2'b11} |=> $stable(st.exception_source_code))
        else $error("source code changed without event");
    AST_RETURN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        interrupt_return_i |=> pc_o == ($past(st.mpc) & 32'h03FF_FFFE) && psw_o == $past(st.mpsw))
        else $error("return restore wrong");
endmodule // crs_register_set

// *** test/crs_pipe_model.sv ***
`timescale 1ns/10ps
// Pipeline stand-in: fetch runs one word ahead of the PC
module crs_pipe_model (
    input wire logic [31:0] pc_i,
    output logic [31:0] next_pc_o
);
    // Raw sum on purpose: dropping the carry past bit 25 is the register set's job
    assign next_pc_o = pc_i + 32'h4;
endmodule // crs_pipe_model

// *** test/test_cpu_register_set_exception_save.sv ***
`timescale 1ns/10ps
module test_cpu_register_set_exception_save;
    localparam logic [6:0] LD = 7'h01, ST = 7'h02, RET = 7'h04, DT = 7'h08, DR = 7'h10, WE = 7'h20, PL = 7'h40;
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    logic [6:0] ctl = 7'h00;
    logic [1:0] ek = 2'h0;
    logic [4:0] ra = 5'h00, rb = 5'h00, sel = 5'h00;
    logic [31:0] val = 32'h0, rda, rdb, ep, pc, npc, program_status_word, srd, p;
    logic err, hold, bad;
    int miscompares = 0, total_checks = 0;
    logic [4:0] rw_n [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h10, 5'h11, 5'h14};
    logic [31:0] rw_m [8] = '{32'h3FFFFFF, 32'hFF, 32'h3FFFFFF, 32'hFF, 32'hFF, 32'h3FFFFFF, 32'hFF, 32'hFFFFFFFF};
    crs_register_set dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .gpr_rd_a_sel_i(ra), .gpr_rd_a_data_o(rda), .gpr_rd_b_sel_i(rb),
        .gpr_rd_b_data_o(rdb), .element_ptr_o(ep), .gpr_wr_en_i(ctl[5]), .gpr_wr_sel_i(sel), .gpr_wr_data_i(val),
        .pc_load_en_i(ctl[6]), .pc_load_value_i(val), .next_pc_i(npc), .pc_o(pc), .psw_flags_en_i(1'h0),
        .psw_flags_i(32'h0), .psw_o(program_status_word), .system_register_load_i(ctl[0]), .system_register_store_i(ctl[1]),
        .sr_sel_i(sel), .sr_wr_data_i(val), .sr_rd_data_o(srd), .sr_access_err_o(err), .exc_kind_i(ek),
        .exc_code_i(val[15:0]), .interrupt_return_i(ctl[2]), .debug_trap_i(ctl[3]), .debug_return_i(ctl[4]),
        .irq_hold_o(hold)
    );
    crs_pipe_model pipe (.pc_i(pc), .next_pc_o(npc));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One request cycle; returns just after the edge that answers it
    task automatic op(input logic [6:0] c, input logic [1:0] k, input logic [4:0] n, input logic [31:0] v);
        @(posedge clk_sys_i);
        ctl <= c;
        ek <= k;
        sel <= n;
        val <= v;
        #1;
        if (c[0])
            check("irq hold", {31'h0, hold}, {31'h0, n == 5'h05});
        @(posedge clk_sys_i);
        ctl <= 7'h00;
        ek <= 2'h0;
        #1;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'h0;
        #1;
        check("psw reset", program_status_word, crs_pkg::PSW_RESET);
        check("err reset", {31'h0, err}, 32'h0);
        for (int i = 0; i < 32; i++)
            op(WE, 2'h0, 5'(i), 32'hC0DE0000 | i);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys_i);
            ra <= 5'(i);
            rb <= 5'(31 - i);
            #1;
            check("gpr a", rda, i == 0 ? 32'h0 : 32'hC0DE0000 | i);
            check("gpr b", rdb, i == 31 ? 32'h0 : 32'hC0DE001F - i);
        end
        check("base ptr", ep, 32'hC0DE001E);
        op(PL, 2'h0, 5'h00, 32'h123);
        check("pc odd", pc, 32'h122);
        op(PL, 2'h0, 5'h00, 32'h3FFFFFC);
        op(7'h00, 2'h0, 5'h00, 32'h0);
        check("pc wrap", pc, 32'h4);
        $display("Test program registers done");
        for (int i = 0; i < 32; i++) begin
            bad = (i > 5 && i < 16) || (i > 17 && i != 20);
            op(LD, 2'h0, 5'(i), 32'hFFFFFFFF);
            check("load err", {31'h0, err}, {31'h0, bad || i == 4});
            op(ST, 2'h0, 5'(i), 32'h0);
            check("store err", {31'h0, err}, {31'h0, bad});
        end
        check("psw load", program_status_word, 32'hFF);
        for (int i = 0; i < 8; i++) begin
            op(ST, 2'h0, rw_n[i], 32'h0);
            check("readback", srd, rw_m[i]);
        end
        op(ST, 2'h0, 5'h04, 32'h0);
        check("code kept", srd, 32'h0);
        $display("Test system registers done");
        op(DT, 2'h0, 5'h00, 32'h0);
        op(LD, 2'h0, 5'h13, 32'h5A);
        op(ST, 2'h0, 5'h13, 32'h0);
        check("debug open", srd, 32'h5A);
        op(DR, 2'h0, 5'h00, 32'h0);
        op(ST, 2'h0, 5'h12, 32'h0);
        check("debug shut", {31'h0, err}, 32'h1);
        $display("Test debug window done");
        for (int k = 1; k < 4; k++) begin
            p = k == 2 ? 32'h3FFFFF8 : 32'h1000 * k;
            op(LD, 2'h0, 5'h05, 32'hC0 | k);
            op(PL, 2'h0, 5'h00, p);
            op(7'h00, 2'(k), 5'h00, 32'hC0 + k);
            op(ST, 2'h0, k == 3 ? 5'h10 : 5'(2 * k - 2), 32'h0);
            check("pc save", srd, (p + 32'h8) & crs_pkg::PC_MASK);
            op(ST, 2'h0, k == 3 ? 5'h11 : 5'(2 * k - 1), 32'h0);
            check("psw save", srd, 32'hC0 | k);
            op(ST, 2'h0, 5'h04, 32'h0);
            check("source", srd, k == 3 ? 32'hC2 : 32'hC0 + k);
        end
        $display("Test event saves done");
        op(LD, 2'h0, 5'h00, 32'h1235);
        op(LD, 2'h0, 5'h01, 32'h11);
        op(RET, 2'h0, 5'h00, 32'h0);
        check("return pc", pc, 32'h1234);
        check("return psw", program_status_word, 32'h11);
        $display("Test interrupt return done");
        end_sim();
    end
endmodule // test_cpu_register_set_exception_save
